//--- rtl/sapo_alert2_top.sv
// Second alert pin setup word and the pin it controls
//
// Functional notes
// RULE1: Word under command 0xD6 is readable and writable; resets to 0x8000.
// RULE2: Bit 15 enables alert on transistor health bad; set from reset.
// RULE3: Bit 14 lets the output overcurrent fault raise the alert.
// RULE4: Bit 13 lets the input overvoltage fault raise the alert.
// RULE5: Bit 12 lets the input undervoltage fault raise the alert.
// RULE6: Bit 11 lets the comms, memory or logic error raise the alert.
// RULE7: Bit 10 lets the output overcurrent warning raise the alert.
// RULE8: Bit 9 lets the second output current warning raise the alert.
// RULE9: Bit 8 lets the input overvoltage warning raise the alert.
// RULE10: Bit 7 lets the input undervoltage warning raise the alert.
// RULE11: Bit 6 lets the output overvoltage warning raise the alert.
// RULE12: Bit 5 lets the output undervoltage warning raise the alert.
// RULE13: Bit 4 lets the hot-swap current limit flag raise the alert.
// RULE14: Bit 3 picks polarity: 0 pulls pin low on alert, 1 high.
// RULE15: Bit 2 is reserved and always reads back as zero.
// RULE16: Bit 1 picks pin use: 0 alert output, 1 general output.
// RULE17: General output mode with bit 0 clear drives the pin low.
// RULE18: General output mode with bit 0 set drives the pin high.
// RULE19: Alert is the OR of enabled flags, then polarity applied.
`timescale 1ns/1ps
`default_nettype none
module sapo_alert2_top
   import sapo_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Command port
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   // Command answer
   output logic rsp_valid,
   output logic rsp_ack,
   output logic [15:0] rsp_rdata,
   // Status flags
   input wire logic pass_transistor_health_bad,
   input wire logic output_overcurrent_fault,
   input wire logic input_overvoltage_fault,
   input wire logic input_undervoltage_fault,
   input wire logic comms_memory_logic_error,
   input wire logic output_overcurrent_warning,
   input wire logic second_output_current_warning,
   input wire logic input_overvoltage_warning,
   input wire logic input_undervoltage_warning,
   input wire logic output_overvoltage_warning,
   input wire logic output_undervoltage_warning,
   input wire logic hot_swap_current_limit_active,
   // Pin and state
   output logic second_alert_or_output_pin,
   output logic alert_active,
   output logic [15:0] second_alert_pin_setup
);

   typedef struct packed {
      logic [15:0] setup;
      logic rsp_valid;
      logic rsp_ack;
      logic [15:0] rsp_rdata;
      logic pin;
      logic active;
   } sapo_state_type;

   sapo_state_type st;
   sapo_state_type next_st;

   logic [15:0] fw;
   logic hit;
   logic wr_en;
   logic [15:0] wr_value;
   logic [15:0] rd_value;
   logic alert_any;
   logic pin_level;

   // Flag group must fill the word above the pin control bits
   if (NUM_FLAGS + FLAG_LSB != 16) begin : g_shape
      $error("sapo_alert2_top: flag group does not fit the word");
   end

   // Flags lined up with their enable bits
   // RULE2: transistor health source
   // RULE3: overcurrent fault source
   // RULE4: input overvoltage fault source
   // RULE5: input undervoltage fault source
   // RULE6: logic error source
   // RULE7: overcurrent warning source
   // RULE8: second current warning source
   // RULE9: input overvoltage warning source
   // RULE10: input undervoltage warning source
   // RULE11: output overvoltage warning source
   // RULE12: output undervoltage warning source
   // RULE13: current limit source
   assign fw = {pass_transistor_health_bad, output_overcurrent_fault,
                input_overvoltage_fault, input_undervoltage_fault,
                comms_memory_logic_error, output_overcurrent_warning,
                second_output_current_warning, input_overvoltage_warning,
                input_undervoltage_warning, output_overvoltage_warning,
                output_undervoltage_warning, hot_swap_current_limit_active,
                4'h0};

   sapo_cmd_decode u_decode (
      .cmd_valid(cmd_valid),
      .cmd_write(cmd_write),
      .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata),
      .setup(st.setup),
      .hit(hit),
      .wr_en(wr_en),
      .wr_value(wr_value),
      .rd_value(rd_value)
   );

   // RULE19: enabled flags merged
   sapo_alert_merge #(
      .N(NUM_FLAGS)
   ) u_merge (
      .flags(fw[15:FLAG_LSB]),
      .enables(st.setup[15:FLAG_LSB]),
      .invert(st.setup[BIT_INVERT]),
      .gpo_mode(st.setup[BIT_GPO_MODE]),
      .gpo_level(st.setup[BIT_GPO_LEVEL]),
      .alert_any(alert_any),
      .pin_level(pin_level)
   );

   always_comb begin
      next_st = st;
      next_st.rsp_valid = cmd_valid;
      next_st.rsp_ack = hit;
      next_st.rsp_rdata = 16'h0000;
      // RULE1: word read and write
      if (hit && !cmd_write) begin
         next_st.rsp_rdata = rd_value;
      end
      // RULE15: reserved bit dropped on write
      if (wr_en) begin
         next_st.setup = wr_value;
      end
      // Pin follows the stored word, so a write shows one cycle after it lands
      next_st.pin = pin_level;
      next_st.active = alert_any;
   end

   always_ff @(posedge ref_clk) begin
      // RULE1: reset value
      if (!rst_n) begin
         st <= '{setup: SETUP_RESET, rsp_valid: 1'b0, rsp_ack: 1'b0,
                 rsp_rdata: 16'h0000, pin: 1'b1, active: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign rsp_valid = st.rsp_valid;
   assign rsp_ack = st.rsp_ack;
   assign rsp_rdata = st.rsp_rdata;
   assign second_alert_or_output_pin = st.pin;
   assign alert_active = st.active;
   assign second_alert_pin_setup = st.setup;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_write;
      cmd_valid && cmd_write && (cmd_code == CMD_SETUP);
   endsequence

   sequence s_read;
      cmd_valid && !cmd_write && (cmd_code == CMD_SETUP);
   endsequence

   sequence s_quiet;
      !(cmd_valid && cmd_write);
   endsequence

   property p_reset_value;
      !$past(rst_n) |-> st.setup == SETUP_RESET;
   endproperty
   a_reset_value: assert property (p_reset_value) // RULE1
      else $error("setup word not at reset value");

   property p_write_store;
      s_write |=> st.setup == ($past(cmd_wdata) & SETUP_RW_MASK);
   endproperty
   a_write_store: assert property (p_write_store) // RULE1
      else $error("written word not stored");

   property p_read_back;
      s_write ##1 s_read |=> rsp_valid && rsp_ack && rsp_rdata == ($past(cmd_wdata, 2) & SETUP_RW_MASK);
   endproperty
   a_read_back: assert property (p_read_back) // RULE1
      else $error("read does not return written word");

   property p_foreign_code;
      cmd_valid && cmd_code != CMD_SETUP |=> rsp_valid && !rsp_ack && $stable(st.setup);
   endproperty
   a_foreign_code: assert property (p_foreign_code) // RULE1
      else $error("other command code touched the word");

   property p_reserved;
      rsp_valid |-> !rsp_rdata[BIT_RESERVED] && !st.setup[BIT_RESERVED];
   endproperty
   a_reserved: assert property (p_reserved) // RULE15
      else $error("reserved bit read as one");

   property p_health;
      st.setup[BIT_HEALTH] && fw[BIT_HEALTH] |=> alert_active;
   endproperty
   a_health: assert property (p_health) // RULE2
      else $error("health flag did not raise alert");

   property p_oc_fault;
      st.setup[BIT_OC_FAULT] && fw[BIT_OC_FAULT] |=> alert_active;
   endproperty
   a_oc_fault: assert property (p_oc_fault) // RULE3
      else $error("overcurrent fault did not raise alert");

   property p_in_overvolt_fault;
      st.setup[BIT_IN_OVERVOLT_FAULT] && fw[BIT_IN_OVERVOLT_FAULT] |=> alert_active;
   endproperty
   a_in_overvolt_fault: assert property (p_in_overvolt_fault) // RULE4
      else $error("input overvoltage fault did not raise alert");

   property p_in_undervolt_fault;
      st.setup[BIT_IN_UNDERVOLT_FAULT] && fw[BIT_IN_UNDERVOLT_FAULT] |=> alert_active;
   endproperty
   a_in_undervolt_fault: assert property (p_in_undervolt_fault) // RULE5
      else $error("input undervoltage fault did not raise alert");

   property p_logic_error;
      st.setup[BIT_LOGIC_ERROR] && fw[BIT_LOGIC_ERROR] |=> alert_active;
   endproperty
   a_logic_error: assert property (p_logic_error) // RULE6
      else $error("logic error did not raise alert");

   property p_oc_warn;
      st.setup[BIT_OC_WARN] && fw[BIT_OC_WARN] |=> alert_active;
   endproperty
   a_oc_warn: assert property (p_oc_warn) // RULE7
      else $error("overcurrent warning did not raise alert");

   property p_warn2;
      st.setup[BIT_WARN2] && fw[BIT_WARN2] |=> alert_active;
   endproperty
   a_warn2: assert property (p_warn2) // RULE8
      else $error("second current warning did not raise alert");

   property p_in_overvolt_warn;
      st.setup[BIT_IN_OVERVOLT_WARN] && fw[BIT_IN_OVERVOLT_WARN] |=> alert_active;
   endproperty
   a_in_overvolt_warn: assert property (p_in_overvolt_warn) // RULE9
      else $error("input overvoltage warning did not raise alert");

   property p_in_undervolt_warn;
      st.setup[BIT_IN_UNDERVOLT_WARN] && fw[BIT_IN_UNDERVOLT_WARN] |=> alert_active;
   endproperty
   a_in_undervolt_warn: assert property (p_in_undervolt_warn) // RULE10
      else $error("input undervoltage warning did not raise alert");

   property p_out_overvolt_warn;
      st.setup[BIT_OUT_OVERVOLT_WARN] && fw[BIT_OUT_OVERVOLT_WARN] |=> alert_active;
   endproperty
   a_out_overvolt_warn: assert property (p_out_overvolt_warn) // RULE11
      else $error("output overvoltage warning did not raise alert");

   property p_out_undervolt_warn;
      st.setup[BIT_OUT_UNDERVOLT_WARN] && fw[BIT_OUT_UNDERVOLT_WARN] |=> alert_active;
   endproperty
   a_out_undervolt_warn: assert property (p_out_undervolt_warn) // RULE12
      else $error("output undervoltage warning did not raise alert");

   property p_hs_limit;
      st.setup[BIT_HS_LIMIT] && fw[BIT_HS_LIMIT] |=> alert_active;
   endproperty
   a_hs_limit: assert property (p_hs_limit) // RULE13
      else $error("current limit flag did not raise alert");

   property p_masked;
      (fw[15:FLAG_LSB] & st.setup[15:FLAG_LSB]) == 12'h000 |=> !alert_active;
   endproperty
   a_masked: assert property (p_masked) // RULE19
      else $error("alert raised with no enabled flag");

   property p_active_low;
      !st.setup[BIT_GPO_MODE] && !st.setup[BIT_INVERT] |=> second_alert_or_output_pin == !alert_active;
   endproperty
   a_active_low: assert property (p_active_low) // RULE14
      else $error("default polarity pin level wrong");

   property p_active_high;
      !st.setup[BIT_GPO_MODE] && st.setup[BIT_INVERT] |=> second_alert_or_output_pin == alert_active;
   endproperty
   a_active_high: assert property (p_active_high) // RULE14
      else $error("inverted polarity pin level wrong");

   property p_gpo_mode;
      st.setup[BIT_GPO_MODE] |=> second_alert_or_output_pin == $past(st.setup[BIT_GPO_LEVEL]);
   endproperty
   a_gpo_mode: assert property (p_gpo_mode) // RULE16
      else $error("general output ignores its level bit");

   property p_gpo_low;
      (s_write and cmd_wdata[1:0] == 2'b10) ##1 s_quiet |=> !second_alert_or_output_pin;
   endproperty
   a_gpo_low: assert property (p_gpo_low) // RULE17
      else $error("general output not driven low");

   property p_gpo_high;
      (s_write and cmd_wdata[1:0] == 2'b11) ##1 s_quiet |=> second_alert_or_output_pin;
   endproperty
   a_gpo_high: assert property (p_gpo_high) // RULE18
      else $error("general output not driven high");

   property p_word_hold;
      s_quiet |=> $stable(st.setup);
   endproperty
   a_word_hold: assert property (p_word_hold) // RULE1
      else $error("word changed without a write");

   property p_read_word;
      s_read |=> rsp_valid && rsp_ack && rsp_rdata == ($past(st.setup) & SETUP_RW_MASK);
   endproperty
   a_read_word: assert property (p_read_word) // RULE1
      else $error("read does not return stored word");

   property p_write_answer;
      s_write |=> rsp_valid && rsp_ack && rsp_rdata == 16'h0000;
   endproperty
   a_write_answer: assert property (p_write_answer) // RULE1
      else $error("write answer wrong");

   property p_answer_pulse;
      !cmd_valid |=> !rsp_valid;
   endproperty
   a_answer_pulse: assert property (p_answer_pulse) // RULE1
      else $error("answer without a command");

   property p_reset_pin;
      !$past(rst_n) |-> second_alert_or_output_pin && !alert_active && !rsp_valid;
   endproperty
   a_reset_pin: assert property (p_reset_pin) // RULE14
      else $error("pin not idle after reset");

endmodule // sapo_alert2_top
`default_nettype wire

//--- include/sapo_pkg.sv
// Constants for the second alert pin setup block
package sapo_pkg;
   // Command code and word layout
   localparam logic [7:0] CMD_SETUP = 8'hD6;
   localparam logic [15:0] SETUP_RESET = 16'h8000;
   localparam logic [15:0] SETUP_RW_MASK = 16'hFFFB;
   // Status flag enable positions
   localparam int BIT_HEALTH = 15;
   localparam int BIT_OC_FAULT = 14;
   localparam int BIT_IN_OVERVOLT_FAULT = 13;
   localparam int BIT_IN_UNDERVOLT_FAULT = 12;
   localparam int BIT_LOGIC_ERROR = 11;
   localparam int BIT_OC_WARN = 10;
   localparam int BIT_WARN2 = 9;
   localparam int BIT_IN_OVERVOLT_WARN = 8;
   localparam int BIT_IN_UNDERVOLT_WARN = 7;
   localparam int BIT_OUT_OVERVOLT_WARN = 6;
   localparam int BIT_OUT_UNDERVOLT_WARN = 5;
   localparam int BIT_HS_LIMIT = 4;
   // Pin control positions
   localparam int BIT_INVERT = 3;
   localparam int BIT_RESERVED = 2;
   localparam int BIT_GPO_MODE = 1;
   localparam int BIT_GPO_LEVEL = 0;
   // Flag group shape
   localparam int NUM_FLAGS = 12;
   localparam int FLAG_LSB = 4;
   // Cycles from a taken command to its answer
   localparam int RSP_LATENCY = 1;
endpackage

//--- rtl/sapo_cmd_decode.sv
// Command decode for the second alert pin setup word
`timescale 1ns/1ps
`default_nettype none
module sapo_cmd_decode
   import sapo_pkg::*;
(
   // Command request
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   // Current word
   input wire logic [15:0] setup,
   // Decoded results
   output logic hit,
   output logic wr_en,
   output logic [15:0] wr_value,
   output logic [15:0] rd_value
);
   always_comb begin
      hit = cmd_valid && (cmd_code == CMD_SETUP);
      wr_en = hit && cmd_write;
      // Reserved bit is never stored, so it cannot leak back on a read
      wr_value = cmd_wdata & SETUP_RW_MASK;
      rd_value = setup & SETUP_RW_MASK;
   end
endmodule // sapo_cmd_decode
`default_nettype wire

//--- rtl/sapo_alert_merge.sv
// Alert source merge, polarity and pin function select
`timescale 1ns/1ps
`default_nettype none
module sapo_alert_merge
   import sapo_pkg::*;
#(
   parameter int N = NUM_FLAGS
)
(
   // Sources and their enables
   input wire logic [N-1:0] flags,
   input wire logic [N-1:0] enables,
   // Pin control
   input wire logic invert,
   input wire logic gpo_mode,
   input wire logic gpo_level,
   // Results
   output logic alert_any,
   output logic pin_level
);
   if (N < 1 || N > 16) begin : g_check
      $error("sapo_alert_merge: N must be 1 to 16");
   end
   always_comb begin
      // RULE19: enabled flags ORed
      alert_any = |(flags & enables);
      // RULE16: pin function select
      if (gpo_mode) begin
         // RULE17: level zero drives low
         // RULE18: level one drives high
         pin_level = gpo_level;
      end else begin
         // RULE14: alert polarity select
         // Default polarity pulls the pin low while any enabled source is active
         pin_level = invert ? alert_any : !alert_any;
      end
   end
endmodule // sapo_alert_merge
`default_nettype wire

//--- tb/sapo_host_model.sv
// Management host model driving the command port of the setup word
`timescale 1ns/1ps
`default_nettype none
module sapo_host_model
   import sapo_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Command out
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   // Answer in
   input wire logic rsp_valid,
   input wire logic rsp_ack,
   input wire logic [15:0] rsp_rdata
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] wd,
      output logic ok, output logic ack, output logic [15:0] rd);
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_code = code;
      cmd_wdata = wd;
      @(negedge ref_clk);
      ok = rsp_valid;
      ack = rsp_ack;
      rd = rsp_rdata;
   endtask
   // Released lines flip so a stale value never passes for a live one
   task automatic release_bus(input int gap);
      cmd_valid = 1'b0;
      cmd_write = ~cmd_write;
      cmd_code = ~cmd_code;
      cmd_wdata = ~cmd_wdata;
      repeat (gap) @(negedge ref_clk);
   endtask
endmodule // sapo_host_model
`default_nettype wire

//--- tb/tb_sapo_alert2_top.sv
// Self-checking bench for the second alert pin setup block
`timescale 1ns/1ps
`default_nettype none
module tb_sapo_alert2_top;
   import sapo_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] flags = 12'h000;
   logic cmd_valid, cmd_write, rsp_valid, rsp_ack, pin, alert_active;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, rsp_rdata, setup;
   int fail_count = 0;
   int comparisons = 0;
   always #4 ref_clk = ~ref_clk;
   sapo_alert2_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
      .rsp_rdata(rsp_rdata), .pass_transistor_health_bad(flags[11]), .output_overcurrent_fault(flags[10]),
      .input_overvoltage_fault(flags[9]), .input_undervoltage_fault(flags[8]),
      .comms_memory_logic_error(flags[7]), .output_overcurrent_warning(flags[6]),
      .second_output_current_warning(flags[5]), .input_overvoltage_warning(flags[4]),
      .input_undervoltage_warning(flags[3]), .output_overvoltage_warning(flags[2]),
      .output_undervoltage_warning(flags[1]), .hot_swap_current_limit_active(flags[0]),
      .second_alert_or_output_pin(pin), .alert_active(alert_active), .second_alert_pin_setup(setup));
   sapo_host_model u_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
      .rsp_rdata(rsp_rdata));
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // One command, answer judged one cycle later
   task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd,
      input logic exp_ack, input logic [15:0] exp_rd);
      logic ok, ack;
      logic [15:0] rd;
      u_host.send(wr, code, wd, ok, ack, rd);
      chk({15'h0000, ok}, 16'h0001);
      chk({15'h0000, ack}, {15'h0000, exp_ack});
      chk(rd, exp_rd);
   endtask
   task automatic put(input logic [15:0] wd);
      cmd(1'b1, CMD_SETUP, wd, 1'b1, 16'h0000);
      u_host.release_bus(1);
   endtask
   task automatic pin_chk(input logic a, input logic p);
      chk({14'h0000, alert_active, pin}, {14'h0000, a, p});
   endtask
   task automatic t_reset();
      chk(setup, SETUP_RESET);
      pin_chk(1'b0, 1'b1);
      cmd(1'b0, CMD_SETUP, 16'h0000, 1'b1, SETUP_RESET);
      u_host.release_bus(1);
   endtask
   task automatic t_health();
      flags = 12'h800;
      @(negedge ref_clk);
      pin_chk(1'b1, 1'b0);
      flags = 12'h000;
      @(negedge ref_clk);
      pin_chk(1'b0, 1'b1);
   endtask
   // Each enable lets only its own flag through
   task automatic t_each();
      for (int i = 0; i < NUM_FLAGS; i++) begin
         put(16'h0010 << i);
         flags = ~(12'h001 << i);
         @(negedge ref_clk);
         pin_chk(1'b0, 1'b1);
         flags = 12'h001 << i;
         @(negedge ref_clk);
         pin_chk(1'b1, 1'b0);
         flags = 12'h000;
      end
   endtask
   task automatic t_polarity();
      put(16'h8008);
      pin_chk(1'b0, 1'b0);
      flags = 12'h800;
      @(negedge ref_clk);
      pin_chk(1'b1, 1'b1);
      flags = 12'h000;
      @(negedge ref_clk);
   endtask
   // Back to back: reserved bit, then refused codes leave the word alone
   task automatic t_reserved();
      cmd(1'b1, CMD_SETUP, 16'hFFFF, 1'b1, 16'h0000);
      cmd(1'b0, CMD_SETUP, 16'h0000, 1'b1, 16'hFFFB);
      cmd(1'b0, 8'hD5, 16'h0000, 1'b0, 16'h0000);
      cmd(1'b1, 8'hD7, 16'h0000, 1'b0, 16'h0000);
      cmd(1'b0, CMD_SETUP, 16'h0000, 1'b1, 16'hFFFB);
      u_host.release_bus(2);
      chk({15'h0000, rsp_valid}, 16'h0000);
   endtask
   task automatic t_gpo();
      flags = 12'hFFF;
      put(16'h100A);
      @(negedge ref_clk);
      pin_chk(1'b1, 1'b0);
      put(16'h0003);
      pin_chk(1'b0, 1'b1);
      put(16'h1003);
      pin_chk(1'b1, 1'b1);
      put(16'h1008);
      pin_chk(1'b1, 1'b1);
      flags = 12'h000;
      @(negedge ref_clk);
   endtask
   task automatic t_rerst();
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      chk(setup, SETUP_RESET);
      pin_chk(1'b0, 1'b1);
   endtask
   initial begin
      repeat (8) @(negedge ref_clk);
      rst_n = 1'b1;
      t_reset();
      t_health();
      t_each();
      t_polarity();
      t_reserved();
      t_gpo();
      t_rerst();
      close_out();
   end
   // A hang ends the run as a mismatch
   initial begin
      #100000;
      fail_count++;
      close_out();
   end
endmodule // tb_sapo_alert2_top
`default_nettype wire
